/* core/pulse_gen_pkg.sv */
// constants and register map of the pulse train generator
// Operation
// - single-shot: enable emits one pulse, self-clears
// - sync mode: one pulse per sync event
// - direct reload copies reload value while idle
// - gradual reload steps toward reload value in sync mode
// - output mode selects single-shot or synchronous
// - prescaler divides system clock by two or four
// - sync event counter counts only when enabled
// - counter clear bit zeroes counter, self-clears
// - trigger edge bit selects falling or rising
// - approach step every 512..4096 generator periods
// - decrement mode: stop, constant or variable step
// - constant step reduces width by n plus one
// - variable step uses stop period over divisor
// - reload is nine bits, bit eight in control
package pulse_gen_pkg;
  localparam logic [7:0] ADDR_CONTROL_MAIN = 8'hb1;
  localparam logic [7:0] ADDR_CONTROL_SYNC = 8'hb2;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'hb3;
  localparam logic [7:0] ADDR_TIMER_LOW = 8'hb6;
  localparam logic [7:0] ADDR_TIMER_HIGH = 8'hb7;
  localparam logic [7:0] ADDR_SYNC_COUNT = 8'hb8;
  // main control fields
  localparam int BIT_OUTPUT_ENABLE = 7;
  localparam int BIT_RELOAD_MODE = 6;
  localparam int BIT_OUTPUT_MODE = 4;
  localparam int BIT_PRESCALE = 3;
  localparam int BIT_COUNT_ENABLE = 2;
  localparam int BIT_COUNT_CLEAR = 1;
  localparam int BIT_TRIGGER_EDGE = 0;
  // sync control fields
  localparam int POS_APPROACH_RATE = 6;
  localparam int POS_DECREMENT_MODE = 4;
  localparam int POS_DECREMENT_STEP = 1;
  localparam int BIT_RELOAD_BIT8 = 0;
  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [7:0] RESET_RELOAD = 8'h00;
  localparam int WIDTH_BITS = 9;
  localparam int APPROACH_BASE_LOG2 = 9;
  localparam int STOP_PERIOD_BITS = 16;
  localparam int DIVIDE_BY_TWO = 2;
  localparam int DIVIDE_BY_FOUR = 4;
  localparam logic [1:0] DEC_CONSTANT = 2'h2;
  localparam logic [1:0] DEC_VARIABLE = 2'h3;
endpackage

/* core/pulse_gen_tick.sv */
// generator clock tick from the system clock
`timescale 1ns/1ps
module pulse_gen_tick (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // control
  input wire logic prescale_four_i,
  // tick out
  output logic tick_o
);
  logic [1:0] div_r;
  logic [1:0] div_nxt;
  wire logic [1:0] div_last = prescale_four_i ?
      2'(pulse_gen_pkg::DIVIDE_BY_FOUR - 1) : 2'(pulse_gen_pkg::DIVIDE_BY_TWO - 1);
  assign div_nxt = (div_r >= div_last) ? 2'h0 : div_r + 2'h1;
  assign tick_o = (div_r == div_last);
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) div_r <= 2'h0;
    else div_r <= div_nxt;
  end
  chk_tick_spacing: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    tick_o && !prescale_four_i && $stable(prescale_four_i)
    |=> !tick_o ##1 (tick_o || prescale_four_i))
    else $error("divide-by-two tick spacing wrong");
endmodule

/* core/pulse_train_generator.sv */
// pulse train generator core with register port
`timescale 1ns/1ps
module pulse_train_generator #(
  parameter int WIDTH_BITS = pulse_gen_pkg::WIDTH_BITS,
  parameter int STOP_PERIOD_BITS = pulse_gen_pkg::STOP_PERIOD_BITS
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // comparator events, asynchronous
  input wire logic sync_comparator_event_i,
  input wire logic stop_comparator_event_i,
  // pulse output
  output logic pulse_o
);
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_PULSE = 1'b1} state_e;
  state_e state_r;
  state_e state_nxt;

  logic [7:0] main_r;
  logic [7:0] sync_r;
  logic [7:0] reload_low_r;
  logic [WIDTH_BITS-1:0] work_r;
  logic [WIDTH_BITS-1:0] work_nxt;
  logic [WIDTH_BITS-1:0] timer_r;
  logic [WIDTH_BITS-1:0] timer_nxt;
  logic [7:0] count_r;
  logic [11:0] approach_r;
  logic [STOP_PERIOD_BITS-1:0] stop_period_r;
  logic [STOP_PERIOD_BITS-1:0] stop_capture_r;
  logic [2:0] sync_sh_r;
  logic [2:0] stop_sh_r;
  logic pulse_r;
  logic [7:0] rdata_r;
  logic [7:0] main_nxt;

  wire logic tick;
  pulse_gen_tick u_tick (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .prescale_four_i(main_r[pulse_gen_pkg::BIT_PRESCALE]),
    .tick_o(tick)
  );

  // control fields
  wire logic out_en = main_r[pulse_gen_pkg::BIT_OUTPUT_ENABLE];
  wire logic reload_gradual = main_r[pulse_gen_pkg::BIT_RELOAD_MODE];
  wire logic sync_mode = main_r[pulse_gen_pkg::BIT_OUTPUT_MODE];
  wire logic count_en = main_r[pulse_gen_pkg::BIT_COUNT_ENABLE];
  wire logic edge_rise = main_r[pulse_gen_pkg::BIT_TRIGGER_EDGE];
  wire logic [1:0] rate = sync_r[pulse_gen_pkg::POS_APPROACH_RATE +: 2];
  wire logic [1:0] dec_mode = sync_r[pulse_gen_pkg::POS_DECREMENT_MODE +: 2];
  wire logic [2:0] dec_step = sync_r[pulse_gen_pkg::POS_DECREMENT_STEP +: 3];
  wire logic [WIDTH_BITS-1:0] reload_val =
      {sync_r[pulse_gen_pkg::BIT_RELOAD_BIT8], reload_low_r};

  // register decode
  wire logic wr_main = reg_wr_i && reg_addr_i == pulse_gen_pkg::ADDR_CONTROL_MAIN;
  wire logic wr_sync = reg_wr_i && reg_addr_i == pulse_gen_pkg::ADDR_CONTROL_SYNC;
  wire logic wr_reload = reg_wr_i && reg_addr_i == pulse_gen_pkg::ADDR_RELOAD_LOW;

  // synchronised comparator inputs; stage 0 is read only by stage 1
  wire logic sync_rise = sync_sh_r[1] && !sync_sh_r[2];
  wire logic sync_fall = !sync_sh_r[1] && sync_sh_r[2];
  wire logic sync_evt = edge_rise ? sync_rise : sync_fall;
  wire logic stop_evt = stop_sh_r[1] && !stop_sh_r[2];

  // pulse launch and end
  wire logic start_single = wr_main && reg_wdata_i[pulse_gen_pkg::BIT_OUTPUT_ENABLE]
      && !reg_wdata_i[pulse_gen_pkg::BIT_OUTPUT_MODE] && state_r == ST_IDLE;
  wire logic start_sync = sync_mode && out_en && sync_evt;
  wire logic pulse_done = state_r == ST_PULSE && tick && timer_r <= 9'(1);
  wire logic stop_halt = sync_mode && stop_evt && !dec_mode[1];

  // approach timer: 512 << rate generator periods
  wire logic [11:0] approach_last =
      12'((1 << (pulse_gen_pkg::APPROACH_BASE_LOG2 + 32'(rate))) - 1);
  wire logic approach_hit = tick && approach_r >= approach_last;

  // variable step: 1 + stop period / (generator period * divisor)
  wire logic [2:0] div_log2 = dec_step[2] ? 3'h3 : 3'(3'h6 - {1'b0, dec_step[1:0]});
  wire logic [STOP_PERIOD_BITS-1:0] var_quot = stop_capture_r >> div_log2;
  wire logic [WIDTH_BITS:0] var_step =
      (var_quot > STOP_PERIOD_BITS'(WIDTH_BITS'('1)))
      ? (WIDTH_BITS+1)'(1) + (WIDTH_BITS+1)'(WIDTH_BITS'('1))
      : (WIDTH_BITS+1)'(1) + (WIDTH_BITS+1)'(var_quot);
  wire logic [WIDTH_BITS:0] const_step = (WIDTH_BITS+1)'(dec_step) + (WIDTH_BITS+1)'(1);
  wire logic [WIDTH_BITS:0] dec_amount = dec_mode[0] ? var_step : const_step;
  wire logic dec_apply = sync_mode && stop_evt && dec_mode[1];
  wire logic [WIDTH_BITS:0] work_ext = {1'b0, work_r};
  wire logic [WIDTH_BITS-1:0] work_dec =
      (work_ext > dec_amount) ? WIDTH_BITS'(work_ext - dec_amount) : WIDTH_BITS'(1);

  // working width update
  always_comb begin
    work_nxt = work_r;
    if (dec_apply) begin
      work_nxt = work_dec;
    end else if (!reload_gradual || !sync_mode) begin
      if (state_r == ST_IDLE) work_nxt = reload_val;
    end else if (approach_hit && work_r != reload_val) begin
      work_nxt = (work_r < reload_val) ? work_r + 9'(1) : work_r - 9'(1);
    end
  end

  // pulse sequencing
  always_comb begin
    state_nxt = state_r;
    timer_nxt = timer_r;
    unique case (state_r)
      ST_IDLE: begin
        if ((start_single || start_sync) && !stop_halt) begin
          state_nxt = ST_PULSE;
          timer_nxt = work_r;
        end
      end
      ST_PULSE: begin
        if (stop_halt) begin
          state_nxt = ST_IDLE;
          timer_nxt = '0;
        end else if (tick) begin
          timer_nxt = timer_r - 9'(1);
          if (timer_r <= 9'(1)) begin
            state_nxt = ST_IDLE;
            timer_nxt = '0;
          end
        end
      end
    endcase
  end

  // main control write with hardware clears
  always_comb begin
    main_nxt = main_r;
    main_nxt[pulse_gen_pkg::BIT_COUNT_CLEAR] = 1'b0;
    if (wr_main) main_nxt = reg_wdata_i;
    if (pulse_done && !sync_mode) main_nxt[pulse_gen_pkg::BIT_OUTPUT_ENABLE] = 1'b0;
    if (stop_halt) main_nxt[pulse_gen_pkg::BIT_OUTPUT_ENABLE] = 1'b0;
  end

  // read mux, timer bytes are read only
  wire logic [7:0] rd_mux =
      (reg_addr_i == pulse_gen_pkg::ADDR_CONTROL_MAIN) ? main_r :
      (reg_addr_i == pulse_gen_pkg::ADDR_CONTROL_SYNC) ? sync_r :
      (reg_addr_i == pulse_gen_pkg::ADDR_RELOAD_LOW) ? reload_low_r :
      (reg_addr_i == pulse_gen_pkg::ADDR_TIMER_LOW) ? timer_r[7:0] :
      (reg_addr_i == pulse_gen_pkg::ADDR_TIMER_HIGH) ? {7'h00, timer_r[8]} :
      (reg_addr_i == pulse_gen_pkg::ADDR_SYNC_COUNT) ? count_r : 8'h00;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      main_r <= pulse_gen_pkg::RESET_CONTROL;
      sync_r <= pulse_gen_pkg::RESET_CONTROL;
      reload_low_r <= pulse_gen_pkg::RESET_RELOAD;
      rdata_r <= 8'h00;
    end else begin
      main_r <= main_nxt;
      if (wr_sync) sync_r <= reg_wdata_i;
      if (wr_reload) reload_low_r <= reg_wdata_i;
      rdata_r <= reg_rd_i ? rd_mux : 8'h00;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sync_sh_r <= 3'h0;
      stop_sh_r <= 3'h0;
    end else begin
      sync_sh_r <= {sync_sh_r[1:0], sync_comparator_event_i};
      stop_sh_r <= {stop_sh_r[1:0], stop_comparator_event_i};
    end
  end

  // event counter; clear wins over a coincident count
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) count_r <= 8'h00;
    else if (main_r[pulse_gen_pkg::BIT_COUNT_CLEAR]) count_r <= 8'h00;
    else if (count_en && sync_evt) count_r <= count_r + 8'h01;
  end

  // stop event period measured in generator ticks, saturating
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      stop_period_r <= '0;
      stop_capture_r <= '0;
    end else if (stop_evt) begin
      stop_capture_r <= stop_period_r;
      stop_period_r <= '0;
    end else if (tick && stop_period_r != '1) begin
      stop_period_r <= stop_period_r + STOP_PERIOD_BITS'(1);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) approach_r <= 12'h000;
    else if (!(sync_mode && reload_gradual) || approach_hit) approach_r <= 12'h000;
    else if (tick) approach_r <= approach_r + 12'h001;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      timer_r <= '0;
      work_r <= '0;
      pulse_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      timer_r <= timer_nxt;
      work_r <= work_nxt;
      pulse_r <= (state_nxt == ST_PULSE);
    end
  end

  assign pulse_o = pulse_r;
  assign reg_rdata_o = rdata_r;

  sequence single_start_s;
    start_single && !stop_halt && work_r != '0;
  endsequence

  chk_single_enable: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    pulse_done && !sync_mode |=> !out_en)
    else $error("enable not cleared after single pulse");
  chk_single_launch: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    single_start_s |=> pulse_o && timer_r == $past(work_r))
    else $error("single pulse not launched with width");
  chk_sync_launch: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    start_sync && state_r == ST_IDLE && !stop_halt |=> state_r == ST_PULSE)
    else $error("sync event did not launch pulse");
  chk_direct_reload: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !reload_gradual && !dec_apply && state_r == ST_IDLE |=> work_r == $past(reload_val))
    else $error("direct reload missing");
  chk_approach_step: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    sync_mode && reload_gradual && !dec_apply && !approach_hit |=> $stable(work_r))
    else $error("working width moved off approach tick");
  chk_count_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !count_en && !main_r[pulse_gen_pkg::BIT_COUNT_CLEAR] |=> $stable(count_r))
    else $error("counter moved while disabled");
  chk_count_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_main && reg_wdata_i[pulse_gen_pkg::BIT_COUNT_CLEAR]
    |=> main_r[pulse_gen_pkg::BIT_COUNT_CLEAR] ##1
        count_r == 8'h00 && !main_r[pulse_gen_pkg::BIT_COUNT_CLEAR])
    else $error("counter clear sequence wrong");
  chk_stop_halt: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    stop_halt |=> !out_en && !pulse_o)
    else $error("stop event did not halt output");
  chk_const_step: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    dec_apply && !dec_mode[0] && work_r > 9'(8)
    |=> work_r == $past(work_r) - 9'($past(dec_step)) - 9'(1))
    else $error("constant decrement step wrong");

  // launch, timing and mode checks
  sequence sync_launch_s;
    start_sync && state_r == ST_IDLE && !stop_halt;
  endsequence

  sequence pulse_end_s;
    pulse_done && !stop_halt;
  endsequence

  sequence count_step_s;
    count_en && sync_evt && !main_r[pulse_gen_pkg::BIT_COUNT_CLEAR];
  endsequence

  sequence approach_move_s;
    sync_mode && reload_gradual && approach_hit && !dec_apply && work_r != reload_val;
  endsequence

  chk_sync_width: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    sync_launch_s |=> timer_r == $past(work_r))
    else $error("sync pulse loaded wrong width");
  chk_sync_busy: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state_r == ST_PULSE && !pulse_done && !stop_halt |=> state_r == ST_PULSE)
    else $error("pulse ended before its timer expired");
  chk_sync_enable: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    sync_mode && pulse_done && !stop_halt && !wr_main |=> out_en == $past(out_en))
    else $error("enable changed at end of sync pulse");
  chk_pulse_end: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    pulse_end_s |=> !pulse_o && state_r == ST_IDLE)
    else $error("pulse did not end when timer expired");
  chk_timer_count: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state_r == ST_PULSE && tick && timer_r > 9'(1) && !stop_halt
    |=> timer_r == $past(timer_r) - 9'(1))
    else $error("width timer did not count down");
  chk_timer_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state_r == ST_PULSE && !tick && !stop_halt |=> $stable(timer_r))
    else $error("width timer moved without a tick");
  chk_idle_timer: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state_r == ST_IDLE |-> timer_r == '0)
    else $error("width timer not zero while idle");
  chk_mode_single: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !sync_mode && !start_single && state_r == ST_IDLE |=> state_r == ST_IDLE)
    else $error("pulse launched without a start in single mode");

  // stop event and width update checks
  chk_halt_idle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    stop_halt |=> state_r == ST_IDLE && timer_r == '0)
    else $error("stop event left the timer running");
  chk_dec_floor: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    dec_apply |=> work_r != '0)
    else $error("decrement drove the width to zero");
  chk_var_step: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    dec_apply && dec_mode[0] |=> work_r < $past(work_r) || work_r == 9'(1))
    else $error("variable decrement did not reduce width");
  chk_stop_restart: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    stop_evt |=> stop_period_r == '0 && stop_capture_r == $past(stop_period_r))
    else $error("stop period not captured");
  chk_approach_move: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    approach_move_s |=> work_r != $past(work_r))
    else $error("working width missed an approach step");
  chk_approach_idle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !(sync_mode && reload_gradual) |=> approach_r == 12'h000)
    else $error("approach timer ran outside gradual sync mode");

  // counter and register checks
  chk_count_step: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    count_step_s |=> count_r == $past(count_r) + 8'h01)
    else $error("enabled counter missed an event");
  chk_clear_self: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    main_r[pulse_gen_pkg::BIT_COUNT_CLEAR] && !wr_main
    |=> !main_r[pulse_gen_pkg::BIT_COUNT_CLEAR])
    else $error("counter clear bit stuck");
  chk_edge_select: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    sync_evt |-> sync_sh_r[1] == edge_rise)
    else $error("sync event on the wrong edge");
  chk_rdata_idle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data outside a read");
  chk_timer_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == pulse_gen_pkg::ADDR_TIMER_LOW
    |=> reg_rdata_o == $past(timer_r[7:0]))
    else $error("timer low byte read wrong");
  chk_reload_bit8: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_sync |=> reload_val[WIDTH_BITS-1] == $past(reg_wdata_i[pulse_gen_pkg::BIT_RELOAD_BIT8]))
    else $error("reload bit eight not taken");
  chk_reload_low: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_reload |=> reload_val[7:0] == $past(reg_wdata_i))
    else $error("reload low byte not taken");
endmodule

/* verif/comparator_model.sv */
// comparator pair model driving the two event pins
`timescale 1ns/1ps
module comparator_model #(
  parameter int HIGH_CYCLES = 20
) (
  // clock
  input wire logic sys_clk_i,
  // requests from the bench
  input wire logic sync_req_i,
  input wire logic stop_req_i,
  // comparator levels
  output logic sync_level_o,
  output logic stop_level_o
);
  int sync_cnt = 0;
  int stop_cnt = 0;
  // each request gives one high level, so one rising and one falling edge
  always @(posedge sys_clk_i) begin
    if (sync_req_i) begin
      sync_cnt <= HIGH_CYCLES;
    end else if (sync_cnt > 0) begin
      sync_cnt <= sync_cnt - 1;
    end
    if (stop_req_i) begin
      stop_cnt <= HIGH_CYCLES;
    end else if (stop_cnt > 0) begin
      stop_cnt <= stop_cnt - 1;
    end
  end
  assign sync_level_o = (sync_cnt > 0);
  assign stop_level_o = (stop_cnt > 0);
endmodule

/* verif/pulse_train_generator_tb_top.sv */
// self-checking bench for the pulse train generator
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module pulse_train_generator_tb_top;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic sync_pin;
  logic stop_pin;
  logic pulse_o;
  logic sync_req = 1'b0;
  logic stop_req = 1'b0;
  int err_count = 0;
  int checks = 0;
  logic [7:0] rv;
  int dly;
  int len;

  always #10 sys_clk_i = ~sys_clk_i;

  pulse_train_generator u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .sync_comparator_event_i(sync_pin),
    .stop_comparator_event_i(stop_pin), .pulse_o(pulse_o));
  comparator_model u_cmp (.sys_clk_i(sys_clk_i), .sync_req_i(sync_req), .stop_req_i(stop_req),
    .sync_level_o(sync_pin), .stop_level_o(stop_pin));

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  task automatic fire(input logic stop);
    @(posedge sys_clk_i);
    if (stop) stop_req <= 1'b1; else sync_req <= 1'b1;
    @(posedge sys_clk_i);
    stop_req <= 1'b0;
    sync_req <= 1'b0;
  endtask

  // delay to the next pulse and its length, len 0 if none comes
  task automatic measure(output int d, output int n);
    d = 0;
    n = 0;
    // sample mid-cycle, away from the edge that launches the pulse
    @(negedge sys_clk_i);
    while (pulse_o !== 1'b1 && d < 100) begin
      @(negedge sys_clk_i);
      d++;
    end
    while (pulse_o === 1'b1 && n < 3000) begin
      @(negedge sys_clk_i);
      n++;
    end
  endtask

  // tick phase makes the length uncertain by one generator period
  function automatic logic fits(input int n, input int w, input int div);
    return (n >= w * div - div + 1) && (n <= w * div + div);
  endfunction

  task automatic test_regs();
    logic [7:0] a [6] = '{8'hb1, 8'hb2, 8'hb3, 8'hb6, 8'hb7, 8'hc0};
    foreach (a[i]) begin
      rd(a[i], rv);
      `CHK(rv, 8'h00)
    end
    wr(8'hb6, 8'hff);
    wr(8'hb7, 8'hff);
    rd(8'hb6, rv);
    `CHK(rv, 8'h00)
    rd(8'hb7, rv);
    `CHK(rv, 8'h00)
    wr(8'hb2, 8'h01);
    wr(8'hb3, 8'h5a);
    rd(8'hb2, rv);
    `CHK(rv, 8'h01)
    rd(8'hb3, rv);
    `CHK(rv, 8'h5a)
    wr(8'hb2, 8'h00);
  endtask

  task automatic test_single();
    wr(8'hb3, 8'h04);
    wr(8'hb1, 8'h80);
    measure(dly, len);
    `CHK(fits(len, 4, 2), 1'b1)
    rd(8'hb1, rv);
    `CHK(rv, 8'h00)
    wr(8'hb1, 8'h88);
    measure(dly, len);
    `CHK(fits(len, 4, 4), 1'b1)
    rd(8'hb1, rv);
    `CHK(rv, 8'h08)
  endtask

  task automatic test_sync();
    wr(8'hb1, 8'h94);
    fire(1'b0);
    measure(dly, len);
    `CHK(dly > 20, 1'b1)
    `CHK(fits(len, 4, 2), 1'b1)
    wr(8'hb1, 8'h95);
    fire(1'b0);
    measure(dly, len);
    `CHK(dly < 10, 1'b1)
    `CHK(fits(len, 4, 2), 1'b1)
    repeat (30) @(posedge sys_clk_i);
    rd(8'hb8, rv);
    `CHK(rv, 8'h02)
    wr(8'hb1, 8'h97);
    rd(8'hb1, rv);
    `CHK(rv, 8'h95)
    rd(8'hb8, rv);
    `CHK(rv, 8'h00)
    wr(8'hb1, 8'h91);
    fire(1'b0);
    repeat (40) @(posedge sys_clk_i);
    rd(8'hb8, rv);
    `CHK(rv, 8'h00)
    fire(1'b1);
    repeat (10) @(posedge sys_clk_i);
    rd(8'hb1, rv);
    `CHK(rv, 8'h11)
    repeat (30) @(posedge sys_clk_i);
    fire(1'b0);
    measure(dly, len);
    `CHK(len, 0)
  endtask

  // step uses the stop period latched at the previous stop event
  task automatic test_dec();
    wr(8'hb3, 8'h20);
    fire(1'b1);
    repeat (166) @(posedge sys_clk_i);
    fire(1'b1);
    wr(8'hb2, 8'h38);
    wr(8'hb1, 8'hd0);
    repeat (30) @(posedge sys_clk_i);
    fire(1'b1);
    repeat (10) @(posedge sys_clk_i);
    fire(1'b0);
    measure(dly, len);
    `CHK(fits(len, 21, 2), 1'b1)
    wr(8'hb2, 8'h24);
    fire(1'b1);
    repeat (10) @(posedge sys_clk_i);
    fire(1'b0);
    measure(dly, len);
    `CHK(fits(len, 18, 2), 1'b1)
    repeat (900) @(posedge sys_clk_i);
    fire(1'b0);
    measure(dly, len);
    `CHK(fits(len, 19, 2), 1'b1)
  endtask

  task automatic finish_test();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    test_regs();
    test_single();
    test_sync();
    test_dec();
    finish_test();
  end

  // the tests need under two thousand cycles, so 20000 means a hang
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    err_count++;
    finish_test();
  end
endmodule
